// ==== hdl/cih_map.vh ====
`ifndef CIH_MAP_VH
`define CIH_MAP_VH
`define CIH_DEV_ADDR 7'h6b
`define CIH_LAST_REG 8'h14
`define CIH_READ_PAST 8'hff
`define CIH_REG_INSRC 8'h00
`define CIH_REG_SYS 8'h03
`define CIH_REG_ICHG 8'h04
`define CIH_REG_WDCTL 8'h07
`define CIH_REG_FAULT 8'h0c
`define CIH_REG_VINTH 8'h0d
`define CIH_RST_INSRC 8'h5c
`define CIH_RST_VOS 8'h01
`define CIH_RST_ADC 8'h01
`define CIH_RST_SYS 8'h1a
`define CIH_RST_ICHG 8'h00
`define CIH_RST_WDCTL 8'h10
`define CIH_RST_OTHER 8'h00
`define CIH_MSK_INSRC 8'hbf
`define CIH_MSK_VOS 8'h01
`define CIH_MSK_ADC 8'hc3
`define CIH_MSK_SYS 8'h1e
`define CIH_MSK_ICHG 8'h3f
`define CIH_MSK_OTHER 8'hff
`define CIH_KEEP_INSRC 8'h3f
`define CIH_KEEP_VOS 8'h01
`define CIH_KEEP_ALL 8'hff
`define CIH_RSVD_ONE 8'h40
`define CIH_BIT_HIZ 7
`define CIH_BIT_KICK 6
`define CIH_WD_LSB 4
`define CIH_CLK_KHZ 20000
`define CIH_INT_PULSE_US 256
`define CIH_INT_PULSE_CYC (`CIH_INT_PULSE_US * `CIH_CLK_KHZ / 1000)
`define CIH_WD_BASE_MS 40000
`define CIH_WD_BASE_CYC (`CIH_WD_BASE_MS * `CIH_CLK_KHZ)
`endif

// ==== hdl/cih_sync.v ====
`default_nettype none
module cih_sync #(
    parameter P_WIDTH = 1,
    parameter [0:0] P_INIT = 1'b0
) (
    input wire i_clock, // sampling clock
    input wire i_rst_n, // async reset, active low
    input wire [P_WIDTH-1:0] i_d, // asynchronous levels
    output wire [P_WIDTH-1:0] o_q // synchronised levels
);
genvar g;
generate
    for (g = 0; g < P_WIDTH; g = g + 1) begin : g_bit
        reg meta_q;
        reg sync_q;
        // meta_q feeds sync_q only
        always @(posedge i_clock or negedge i_rst_n) begin
            if (!i_rst_n) begin
                meta_q <= P_INIT;
                sync_q <= P_INIT;
            end else begin
                meta_q <= i_d[g];
                sync_q <= meta_q;
            end
        end
        assign o_q[g] = sync_q;
    end
endgenerate
endmodule
`default_nettype wire

// ==== hdl/cih_wdog.v ====
`default_nettype none
module cih_wdog #(
    parameter [31:0] P_BASE = 32'h0000_0064
) (
    input wire i_clock, // system clock
    input wire i_rst_n, // async reset, active low
    input wire i_kick, // restart pulse
    input wire [1:0] i_period, // period code, 00 off
    output reg o_expire // one-cycle expiry pulse
);
reg [31:0] cnt_q;
reg [31:0] limit;

always @* begin
    case (i_period)
        2'b01: limit = P_BASE;
        2'b10: limit = {P_BASE[30:0], 1'b0};
        2'b11: limit = {P_BASE[29:0], 2'b00};
        default: limit = 32'h0000_0000;
    endcase
end

always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
        cnt_q <= 32'h0000_0000;
        o_expire <= 1'b0;
    end else begin
        o_expire <= 1'b0;
        if (i_kick || i_period == 2'b00) begin
            cnt_q <= 32'h0000_0000;
        end else if (cnt_q >= limit - 32'h0000_0001) begin
            cnt_q <= 32'h0000_0000;
            o_expire <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
        end
    end
end
endmodule
`default_nettype wire

// ==== hdl/cih_top.v ====
`include "cih_map.vh"
`default_nettype none
module cih_top #(
    parameter [15:0] P_INT_CYCLES = `CIH_INT_PULSE_CYC, // host interrupt pulse length
    parameter [31:0] P_WD_BASE = `CIH_WD_BASE_CYC // shortest watchdog period
) (
    input wire i_clock, // 20 MHz system clock
    input wire i_rst_n, // async reset, active low
    input wire i_scl, // bus clock pin level
    input wire i_sda, // bus data pin level
    output reg o_sda, // data drive value, always low
    output reg o_sda_oe, // data pull-down enable
    input wire [6:0] i_faults, // live faults, [2:0] thermistor
    input wire [5:0] i_current_limit_pin_pin_code, // limit set by current limit pin
    input wire i_detect_done, // source detection finished, pulse
    input wire [5:0] i_detect_code, // limit chosen for detected source
    output reg o_hiz_enable, // high-impedance mode request
    output reg [5:0] o_iin_limit, // applied input current limit code
    output reg [5:0] o_chg_current, // fast-charge current code
    output reg o_default_mode, // device in default mode
    output reg o_host_int // fault interrupt pulse
);

////////////////////////////////////////////////////////////////////////////////
localparam [4:0] S_IDLE = 5'b00001;
localparam [4:0] S_ADDR = 5'b00010;
localparam [4:0] S_REG = 5'b00100;
localparam [4:0] S_WR = 5'b01000;
localparam [4:0] S_RD = 5'b10000;
localparam N_REGS = 21;

function is_defined;
    input [7:0] a;
    begin
        is_defined = (a <= `CIH_LAST_REG);
    end
endfunction

function [7:0] rst_val;
    input [4:0] i;
    begin
        case (i)
            5'h00: rst_val = `CIH_RST_INSRC;
            5'h01: rst_val = `CIH_RST_VOS;
            5'h02: rst_val = `CIH_RST_ADC;
            5'h03: rst_val = `CIH_RST_SYS;
            5'h04: rst_val = `CIH_RST_ICHG;
            5'h07: rst_val = `CIH_RST_WDCTL;
            default: rst_val = `CIH_RST_OTHER;
        endcase
    end
endfunction

function [7:0] wr_mask;
    input [4:0] i;
    begin
        case (i)
            5'h00: wr_mask = `CIH_MSK_INSRC;
            5'h01: wr_mask = `CIH_MSK_VOS;
            5'h02: wr_mask = `CIH_MSK_ADC;
            5'h03: wr_mask = `CIH_MSK_SYS;
            5'h04: wr_mask = `CIH_MSK_ICHG;
            5'h0c: wr_mask = 8'h00;
            default: wr_mask = `CIH_MSK_OTHER;
        endcase
    end
endfunction

// bits that survive watchdog expiry
function [7:0] keep_mask;
    input [4:0] i;
    begin
        case (i)
            5'h00: keep_mask = `CIH_KEEP_INSRC;
            5'h01: keep_mask = `CIH_KEEP_VOS;
            5'h0d: keep_mask = `CIH_KEEP_ALL;
            default: keep_mask = 8'h00;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
wire rst_n;
wire [1:0] pins_s;
wire scl_s;
wire sda_s;
reg scl_d_q;
reg sda_d_q;

cih_sync #(.P_WIDTH(1), .P_INIT(1'b0)) u_rst_sync (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_d(1'b1),
    .o_q(rst_n)
);

cih_sync #(.P_WIDTH(2), .P_INIT(1'b1)) u_pin_sync (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_d({i_scl, i_sda}),
    .o_q(pins_s)
);

assign scl_s = pins_s[1];
assign sda_s = pins_s[0];

wire scl_rise = scl_s & ~scl_d_q;
wire scl_fall = ~scl_s & scl_d_q;
wire start_c = scl_s & scl_d_q & sda_d_q & ~sda_s;
wire stop_c = scl_s & scl_d_q & ~sda_d_q & sda_s;

////////////////////////////////////////////////////////////////////////////////
reg [4:0] state_q;
reg [3:0] cnt_q;
reg ack_q;
reg rd_go_q;
reg [7:0] shift_q;
reg [7:0] tx_q;
reg [7:0] ptr_q;
reg wr_stb_q;
reg [4:0] wr_idx_q;
reg [7:0] wr_data_q;
reg fault_rd_q;
reg [7:0] regs_q [0:N_REGS-1];
reg [7:3] fault_q;
reg [7:0] rd_val;
wire wd_expire;

always @* begin
    if (!is_defined(ptr_q)) begin
        rd_val = `CIH_READ_PAST;
    end else if (ptr_q == `CIH_REG_FAULT) begin
        rd_val = {fault_q, i_faults[2:0]};
    end else if (ptr_q == `CIH_REG_INSRC) begin
        rd_val = regs_q[0] | `CIH_RSVD_ONE;
    end else begin
        rd_val = regs_q[ptr_q[4:0]];
    end
end

// no clock stretching: a 20 MHz core keeps up with 400 kHz bus rates
always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
        state_q <= S_IDLE;
        cnt_q <= 4'h0;
        ack_q <= 1'b0;
        rd_go_q <= 1'b0;
        shift_q <= 8'h00;
        tx_q <= 8'h00;
        ptr_q <= 8'h00;
        o_sda <= 1'b0;
        o_sda_oe <= 1'b0;
        wr_stb_q <= 1'b0;
        wr_idx_q <= 5'h00;
        wr_data_q <= 8'h00;
        fault_rd_q <= 1'b0;
        scl_d_q <= 1'b1;
        sda_d_q <= 1'b1;
    end else begin
        scl_d_q <= scl_s;
        sda_d_q <= sda_s;
        wr_stb_q <= 1'b0;
        fault_rd_q <= 1'b0;
        if (start_c) begin
            state_q <= S_ADDR;
            cnt_q <= 4'h0;
            ack_q <= 1'b0;
            o_sda_oe <= 1'b0;
        end else if (stop_c) begin
            state_q <= S_IDLE;
            o_sda_oe <= 1'b0;
        end else if (state_q != S_IDLE) begin
            if (scl_rise) begin
                if (!ack_q) begin
                    shift_q <= {shift_q[6:0], sda_s};
                    cnt_q <= cnt_q + 4'h1;
                end else if (state_q == S_RD) begin
                    rd_go_q <= ~sda_s;
                end
            end else if (scl_fall) begin
                if (ack_q) begin
                    ack_q <= 1'b0;
                    cnt_q <= 4'h0;
                    if (state_q == S_RD && rd_go_q) begin
                        tx_q <= {rd_val[6:0], 1'b0};
                        o_sda_oe <= ~rd_val[7];
                        fault_rd_q <= (ptr_q == `CIH_REG_FAULT);
                        // fault register holds the pointer for a second read
                        if (is_defined(ptr_q) && ptr_q != `CIH_REG_FAULT) begin
                            ptr_q <= ptr_q + 8'h01;
                        end
                    end else begin
                        o_sda_oe <= 1'b0;
                        if (state_q == S_RD) begin
                            state_q <= S_IDLE;
                        end
                    end
                end else if (cnt_q == 4'h8) begin
                    ack_q <= 1'b1;
                    case (state_q)
                        S_ADDR: begin
                            if (shift_q[7:1] == `CIH_DEV_ADDR) begin
                                o_sda_oe <= 1'b1;
                                rd_go_q <= shift_q[0];
                                state_q <= shift_q[0] ? S_RD : S_REG;
                            end else begin
                                o_sda_oe <= 1'b0;
                                state_q <= S_IDLE;
                            end
                        end
                        S_REG: begin
                            if (is_defined(shift_q)) begin
                                ptr_q <= shift_q;
                                o_sda_oe <= 1'b1;
                                state_q <= S_WR;
                            end else begin
                                o_sda_oe <= 1'b0;
                                state_q <= S_IDLE;
                            end
                        end
                        S_WR: begin
                            if (is_defined(ptr_q)) begin
                                o_sda_oe <= 1'b1;
                                wr_stb_q <= 1'b1;
                                wr_idx_q <= ptr_q[4:0];
                                wr_data_q <= shift_q;
                                if (ptr_q != `CIH_REG_FAULT) begin
                                    ptr_q <= ptr_q + 8'h01;
                                end
                            end else begin
                                o_sda_oe <= 1'b0;
                                state_q <= S_IDLE;
                            end
                        end
                        S_RD: o_sda_oe <= 1'b0;
                        default: state_q <= S_IDLE;
                    endcase
                end else if (state_q == S_RD) begin
                    o_sda_oe <= ~tx_q[7];
                    tx_q <= {tx_q[6:0], 1'b0};
                end
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
wire kick = wr_stb_q && wr_idx_q == `CIH_REG_SYS && wr_data_q[`CIH_BIT_KICK];

cih_wdog #(.P_BASE(P_WD_BASE)) u_wdog (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_kick(kick),
    .i_period(regs_q[7][`CIH_WD_LSB+1:`CIH_WD_LSB]),
    .o_expire(wd_expire)
);

integer k;
always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
        for (k = 0; k < N_REGS; k = k + 1) begin
            regs_q[k] <= rst_val(k[4:0]);
        end
    end else begin
        if (wd_expire) begin
            for (k = 0; k < N_REGS; k = k + 1) begin
                regs_q[k] <= (regs_q[k] & keep_mask(k[4:0]))
                    | (rst_val(k[4:0]) & ~keep_mask(k[4:0]));
            end
        end else if (wr_stb_q) begin
            regs_q[wr_idx_q] <= (regs_q[wr_idx_q] & ~wr_mask(wr_idx_q))
                | (wr_data_q & wr_mask(wr_idx_q));
        end
        if (i_detect_done) begin
            regs_q[0][5:0] <= i_detect_code;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
reg int_block_q;
reg [15:0] int_cnt_q;
wire [3:0] new_flt = i_faults[6:3] & ~fault_q[6:3];
wire fire = ~int_block_q & ((|new_flt) | (wd_expire & ~fault_q[7]));

always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
        fault_q <= 5'h00;
        int_block_q <= 1'b0;
        int_cnt_q <= 16'h0000;
        o_host_int <= 1'b0;
    end else begin
        // new events are kept even on the read that clears the latch
        if (fault_rd_q) begin
            fault_q <= {wd_expire, i_faults[6:3]};
        end else begin
            fault_q <= fault_q | {wd_expire, i_faults[6:3]};
        end
        if (fire) begin
            int_block_q <= 1'b1;
        end else if (fault_rd_q && i_faults == 7'h00) begin
            int_block_q <= 1'b0;
        end
        if (fire) begin
            int_cnt_q <= P_INT_CYCLES;
            o_host_int <= 1'b1;
        end else if (int_cnt_q != 16'h0000) begin
            int_cnt_q <= int_cnt_q - 16'h0001;
            o_host_int <= (int_cnt_q != 16'h0001);
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
        o_hiz_enable <= 1'b0;
        o_iin_limit <= 6'h00;
        o_chg_current <= 6'h00;
        o_default_mode <= 1'b1;
    end else begin
        o_hiz_enable <= regs_q[0][`CIH_BIT_HIZ];
        o_iin_limit <= (regs_q[0][5:0] < i_current_limit_pin_pin_code) ?
            regs_q[0][5:0] : i_current_limit_pin_pin_code;
        o_chg_current <= regs_q[4][5:0];
        if (wd_expire) begin
            o_default_mode <= 1'b1;
        end else if (wr_stb_q) begin
            o_default_mode <= 1'b0;
        end
    end
end
endmodule
`default_nettype wire

// ==== sim/cih_top_assertions.sv ====
`default_nettype none
module cih_top_assertions #(
    parameter [15:0] P_INT_CYCLES = 16'h0008,
    parameter [31:0] P_WD_BASE = 32'h0000_00c8
) (
    input wire logic i_clock, // system clock
    input wire logic i_rst_n, // async reset
    input wire logic i_scl, // bus clock wire
    input wire logic i_sda, // bus data wire
    input wire logic o_sda, // data drive value
    input wire logic o_sda_oe, // data pull enable
    input wire logic [6:0] i_faults, // live faults
    input wire logic [5:0] i_current_limit_pin_pin_code, // pin limit
    input wire logic i_detect_done, // detection pulse
    input wire logic [5:0] i_detect_code, // detected limit
    input wire logic o_hiz_enable, // high-impedance request
    input wire logic [5:0] o_iin_limit, // applied limit
    input wire logic [5:0] o_chg_current, // charge current
    input wire logic o_default_mode, // default mode
    input wire logic o_host_int // interrupt pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] int_len_q;
    logic [5:0] det_q;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            int_len_q <= 16'h0000;
            det_q <= 6'h00;
        end else begin
            int_len_q <= o_host_int ? int_len_q + 16'h0001 : 16'h0000;
            if (i_detect_done) begin
                det_q <= (i_detect_code < i_current_limit_pin_pin_code) ? i_detect_code : i_current_limit_pin_pin_code;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    sequence s_start;
        i_scl && $fell(i_sda);
    endsequence
    sequence s_wd_expiry;
        $rose(o_default_mode);
    endsequence
    a_drive_only_low: assert property (o_sda_oe |-> !o_sda)
        else $error("data driven high");
    a_ack_through_high: assert property (o_sda_oe && $rose(i_scl) |-> o_sda_oe [*3])
        else $error("data pull dropped in clock high");
    a_drive_scl_low: assert property ($rose(o_sda_oe) |-> !i_scl)
        else $error("data pulled while clock high");
    a_start_quiet: assert property (s_start |-> !o_sda_oe [*8])
        else $error("data pulled right after start");
    a_iin_below_pin: assert property ($stable(i_current_limit_pin_pin_code) |-> o_iin_limit <= i_current_limit_pin_pin_code)
        else $error("applied limit above pin limit");
    a_detect_load: assert property (i_detect_done |-> ##[2:3] o_iin_limit == det_q)
        else $error("detected limit not applied");
    a_int_width: assert property ($fell(o_host_int) |-> int_len_q == P_INT_CYCLES)
        else $error("interrupt pulse width wrong");
    a_wd_hiz_clear: assert property (s_wd_expiry |-> ##[0:2] !o_hiz_enable)
        else $error("high-impedance kept after expiry");
    a_wd_chg_zero: assert property (s_wd_expiry |-> ##[0:2] o_chg_current == 6'h00)
        else $error("charge current kept after expiry");
    a_wd_keep_iin: assert property (s_wd_expiry |-> $stable(o_iin_limit) [*3])
        else $error("input limit lost on expiry");
endmodule
`default_nettype wire

// ==== sim/cih_host_model.sv ====
`default_nettype none
module cih_host_model (
    output var logic o_scl, // bus clock, high when idle
    output var logic o_sda_low, // pulls data low
    input wire logic i_sda // resolved data wire
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int Q = 100;
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    // data moves only a quarter period after the clock fell
    task automatic bit_x(input logic v, output logic r);
        o_sda_low = !v;
        #Q;
        o_scl = 1'b1;
        #Q;
        r = i_sda;
        #Q;
        o_scl = 1'b0;
        #Q;
    endtask
    task automatic start();
        #13;
        if (!o_scl) begin
            o_sda_low = 1'b0;
            #Q;
            o_scl = 1'b1;
            #Q;
        end
        o_sda_low = 1'b1;
        #Q;
        o_scl = 1'b0;
        #Q;
    endtask
    task automatic stop();
        o_sda_low = 1'b1;
        #Q;
        o_scl = 1'b1;
        #Q;
        o_sda_low = 1'b0;
        #Q;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(b[i], r);
        end
        bit_x(1'b1, ack);
    endtask
    task automatic rbyte(output logic [7:0] b, input logic last);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            b[i] = r;
        end
        bit_x(last, r);
    endtask
endmodule
`default_nettype wire

// ==== sim/charger_i2c_host_interface_tb_top.sv ====
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module charger_i2c_host_interface_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clock, i_rst_n, i_detect_done, host_low, int_prev;
    logic [6:0] i_faults;
    logic [5:0] i_current_limit_pin_pin_code, i_detect_code;
    wire logic i_scl, o_sda, o_sda_oe, o_hiz_enable, o_default_mode, o_host_int;
    wire logic [5:0] o_iin_limit, o_chg_current;
    wire logic i_sda = (o_sda_oe ? o_sda : 1'b1) & ~host_low;
    int num_errors = 0, num_checks = 0, cycles = 0;
    logic [7:0] rises = 8'h00;
    cih_top #(.P_INT_CYCLES(16'h0008), .P_WD_BASE(32'h0000_0fa0)) DUT (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda(i_sda),
        .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_faults(i_faults),
        .i_current_limit_pin_pin_code(i_current_limit_pin_pin_code), .i_detect_done(i_detect_done),
        .i_detect_code(i_detect_code), .o_hiz_enable(o_hiz_enable),
        .o_iin_limit(o_iin_limit), .o_chg_current(o_chg_current),
        .o_default_mode(o_default_mode), .o_host_int(o_host_int));
    cih_host_model u_host (.o_scl(i_scl), .o_sda_low(host_low), .i_sda(i_sda));
    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // hang guard sized well above the whole sequence
    always @(posedge i_clock) begin
        int_prev <= o_host_int;
        if (o_host_int === 1'b1 && int_prev === 1'b0) rises <= rises + 8'h01;
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            complete_run();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    task automatic ack_chk(input logic [7:0] b, input logic exp);
        logic a;
        u_host.wbyte(b, a);
        `CHK(a, exp)
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1, input int n);
        u_host.start();
        ack_chk(8'hd6, 1'b0);
        ack_chk(a, 1'b0);
        ack_chk(d0, 1'b0);
        if (n > 1) ack_chk(d1, 1'b0);
        u_host.stop();
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1, input int n);
        logic [7:0] b;
        u_host.start();
        ack_chk(8'hd6, 1'b0);
        ack_chk(a, 1'b0);
        u_host.start();
        ack_chk(8'hd7, 1'b0);
        u_host.rbyte(b, n == 1);
        `CHK(b, e0)
        if (n > 1) begin
            u_host.rbyte(b, 1'b1);
            `CHK(b, e1)
        end
        u_host.stop();
    endtask
    initial begin
        i_rst_n = 1'b0;
        i_faults = 7'h00;
        i_current_limit_pin_pin_code = 6'h3f;
        i_detect_done = 1'b0;
        i_detect_code = 6'h00;
        repeat (16) @(posedge i_clock);
        #1;
        i_rst_n = 1'b1;
        tick(8);
        `CHK(o_chg_current, 6'h00)
        `CHK(o_iin_limit, 6'h1c)
        wr(8'h07, 8'h00, 8'h00, 1);
        rd(8'h00, 8'h5c, 8'h01, 2);
        u_host.start();
        ack_chk(8'hd4, 1'b1);
        u_host.stop();
        u_host.start();
        ack_chk(8'hd6, 1'b0);
        ack_chk(8'h15, 1'b1);
        u_host.stop();
        rd(8'h14, 8'h00, 8'hff, 2);
        wr(8'h00, 8'h85, 8'hff, 2);
        rd(8'h00, 8'hc5, 8'h01, 2);
        `CHK(o_hiz_enable, 1'b1)
        `CHK(o_iin_limit, 6'h05)
        i_current_limit_pin_pin_code = 6'h02;
        tick(3);
        `CHK(o_iin_limit, 6'h02)
        i_current_limit_pin_pin_code = 6'h3f;
        wr(8'h04, 8'hea, 8'h00, 1);
        rd(8'h04, 8'h2a, 8'h00, 1);
        `CHK(o_chg_current, 6'h2a)
        tick(4500);
        `CHK(o_default_mode, 1'b0)
        i_detect_code = 6'h11;
        i_detect_done = 1'b1;
        tick(1);
        i_detect_done = 1'b0;
        rd(8'h00, 8'hd1, 8'h00, 1);
        // second fault arrives while the first is still unread
        i_faults = 7'h08;
        tick(20);
        i_faults = 7'h18;
        tick(20);
        `CHK(rises, 8'h01)
        i_faults = 7'h00;
        tick(2);
        rd(8'h0c, 8'h18, 8'h00, 2);
        i_faults = 7'h20;
        tick(20);
        `CHK(rises, 8'h02)
        i_faults = 7'h01;
        tick(2);
        rd(8'h0c, 8'h21, 8'h00, 1);
        i_faults = 7'h00;
        tick(2);
        rd(8'h0c, 8'h00, 8'h00, 1);
        wr(8'h07, 8'h10, 8'h00, 1);
        wr(8'h03, 8'h5a, 8'h00, 1);
        rd(8'h03, 8'h1a, 8'h00, 1);
        tick(2500);
        wr(8'h03, 8'h5a, 8'h00, 1);
        tick(3000);
        `CHK(o_default_mode, 1'b0)
        for (int k = 0; k < 2000 && o_default_mode !== 1'b1; k++) tick(1);
        `CHK(o_default_mode, 1'b1)
        tick(3);
        `CHK(o_hiz_enable, 1'b0)
        `CHK(o_chg_current, 6'h00)
        `CHK(o_iin_limit, 6'h11)
        rd(8'h0c, 8'h80, 8'h00, 1);
        // longest period code: four base periods before expiry
        wr(8'h07, 8'h30, 8'h00, 1);
        wr(8'h03, 8'h5a, 8'h00, 1);
        tick(15500);
        `CHK(o_default_mode, 1'b0)
        for (int k = 0; k < 1000 && o_default_mode !== 1'b1; k++) tick(1);
        `CHK(o_default_mode, 1'b1)
        complete_run();
    end
endmodule
bind cih_top cih_top_assertions #(.P_INT_CYCLES(P_INT_CYCLES), .P_WD_BASE(P_WD_BASE)) u_chk (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda(i_sda),
    .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_faults(i_faults),
    .i_current_limit_pin_pin_code(i_current_limit_pin_pin_code), .i_detect_done(i_detect_done),
    .i_detect_code(i_detect_code), .o_hiz_enable(o_hiz_enable),
    .o_iin_limit(o_iin_limit), .o_chg_current(o_chg_current),
    .o_default_mode(o_default_mode), .o_host_int(o_host_int));
`default_nettype wire
